// *** core/pfcs_pkg.sv ***
// Package for the pin function and channel select bank.
// Assumes an 8-bit register port with byte offsets as listed.
package pfcs_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PIN_ONE   = 8'h10;
    localparam logic [7:0] OFF_PIN_TWO   = 8'h11;
    localparam logic [7:0] OFF_PIN_THREE = 8'h12;
    localparam logic [7:0] OFF_PIN_FOUR  = 8'h13;
    localparam logic [7:0] OFF_PRESET    = 8'h14;
    localparam logic [7:0] OFF_CHAN      = 8'h16;

    // ----------------------------------------
    // Reset values and writable masks
    // ----------------------------------------
    localparam logic [7:0] RST_PIN_ONE   = 8'h7F;
    localparam logic [7:0] RST_PIN_TWO   = 8'hCE;
    localparam logic [7:0] RST_PIN_THREE = 8'h42;
    localparam logic [7:0] RST_PIN_FOUR  = 8'hFC;
    localparam logic [7:0] RST_PRESET    = 8'h01;
    localparam logic [7:0] RST_CHAN      = 8'h00;
    localparam logic [7:0] MSK_ALL       = 8'hFF;
    localparam logic [7:0] MSK_PIN_THREE = 8'hFE;
    localparam logic [7:0] MSK_PIN_FOUR  = 8'hFC;
    localparam logic [7:0] MSK_PRESET    = 8'h1F;

    // ----------------------------------------
    // Field encodings
    // ----------------------------------------
    localparam logic [1:0] SEL2_00 = 2'h0;
    localparam logic [1:0] SEL2_01 = 2'h1;
    localparam logic [1:0] SEL2_10 = 2'h2;
    localparam logic [1:0] SEL2_11 = 2'h3;

    // Rail choice for pins 23 and 24
    typedef enum logic [1:0] {
        PFCS_RAIL_CORE = 2'h0,
        PFCS_RAIL_2V5  = 2'h1,
        PFCS_RAIL_1V8  = 2'h2,
        PFCS_RAIL_1V5  = 2'h3
    } pfcs_rail_t;

    // Three-way role of pins 25, 26, 28, 29
    typedef enum logic [1:0] {
        PFCS_ROLE_BASE  = 2'h0,
        PFCS_ROLE_ALT   = 2'h1,
        PFCS_ROLE_ALARM = 2'h2
    } pfcs_role3_t;

    // Decoded pin functions: flags, plus codes for rails and three-way roles
    typedef struct packed {
        logic        first_12v_monitor;
        logic        fan_speed_input_five;
        logic [3:0]  fan_speed_input_1_4;
        logic [3:0]  gpio_1_4;
        logic        remote_diode_three_pair;
        logic        termination_sense_two;
        logic        remote_diode_one_pair;
        logic        termination_sense_one;
        logic        voltage_identification_inputs;
        pfcs_rail_t  pin23_rail;
        logic [2:0]  fan_speed_input_6_8;
        logic        pin19_low_scale;
        logic        pin15_low_scale;
        logic        pwm_four_drive;
        logic        chassis_intrusion;
        logic        force_fan_full_input;
        pfcs_role3_t pin25_role;
        pfcs_role3_t pin26_role;
        pfcs_rail_t  pin24_rail;
        logic [1:0]  pwm_1_2_drive;
        logic [1:0]  gpio_5_6;
        pfcs_role3_t pin28_role;
        pfcs_role3_t pin29_role;
        logic [4:0]  preset_enable;
        logic [1:0]  special_output_enable;
        logic        single_channel_mode;
        logic [4:0]  channel_select;
    } pfcs_func_t;

endpackage

// *** core/pfcs_reg8.sv ***
// One 8-bit configuration register with a writable mask.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module pfcs_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hFF
) (
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    input  wire logic       sw_reset_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] value_o
);
    logic [7:0] value_d;

    // Reserved bits hold their reset value
    assign value_d = sw_reset_i ? RESET_VAL
                   : we_i ? ((wdata_i & WR_MASK) | (RESET_VAL & ~WR_MASK))
                   : value_o;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            value_o <= RESET_VAL;
        end else begin
            value_o <= value_d;
        end
    end
endmodule

// *** core/pfcs_top.sv ***
// Pin function and channel select register bank with pin role decode.
// Assumes a plain register port synchronous to clock_i; read data one cycle after the strobe.
//
// Functional notes
// - Pin 7 bit0: 12V monitor or fan five
// - Pins 4..1: GPIO or fan, unless VID
// - Bit5 set gives pins 19/20 diode three
// - Bit6 set gives pins 15/16 diode one
// - Bit7 makes seven pins VID inputs
// - Pin 23 rail select, default 1.8 V
// - Pins 22,21,8: voltage or fan 8,7,6
// - Pin 19/15 scaling when diode off
// - Pin 13: 3.3 V monitor or PWM four
// - Pin 27: force-fan input or intrusion
// - Pin 25: 3.3V, 1.2V, or overtemp one
// - Pin 24 rail select, default 2.5 V
// - Pin 26: battery, bus rail, overtemp two
// - Pins 32/31: GPIO or PWM, VID overrides
// - Pin 29: GPIO8, 1.5V, or alarm two
// - Pin 28: GPIO7, 1.5V, or alarm one
// - Five preset enables, reserved bits read zero
// - Special output enables on GPIO five, six
// - Single-channel mode stops round robin
// - Five-bit channel select, default pin 26
// - Lock protects, soft reset restores defaults
`timescale 1ns/1ps
module pfcs_top (
    input  wire logic              clock_i,
    input  wire logic              arst_n_i,
    input  wire logic              sw_reset_i,
    input  wire logic              lock_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    output pfcs_pkg::pfcs_func_t   func_o
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic       wr_ok;
    logic       we_one;
    logic       we_two;
    logic       we_three;
    logic       we_four;
    logic       we_preset;
    logic       we_chan;
    logic [7:0] pin_one;
    logic [7:0] pin_two;
    logic [7:0] pin_three;
    logic [7:0] pin_four;
    logic [7:0] preset;
    logic [7:0] chan;

    assign wr_ok     = wr_i & ~lock_i;
    assign we_one    = wr_ok & (addr_i == pfcs_pkg::OFF_PIN_ONE);
    assign we_two    = wr_ok & (addr_i == pfcs_pkg::OFF_PIN_TWO);
    assign we_three  = wr_ok & (addr_i == pfcs_pkg::OFF_PIN_THREE);
    assign we_four   = wr_ok & (addr_i == pfcs_pkg::OFF_PIN_FOUR);
    assign we_preset = wr_ok & (addr_i == pfcs_pkg::OFF_PRESET);
    assign we_chan   = wr_ok & (addr_i == pfcs_pkg::OFF_CHAN);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    pfcs_reg8 #(.RESET_VAL(pfcs_pkg::RST_PIN_ONE), .WR_MASK(pfcs_pkg::MSK_ALL)) u_one (
        .clock_i    (clock_i),
        .arst_n_i   (arst_n_i),
        .sw_reset_i (sw_reset_i),
        .we_i       (we_one),
        .wdata_i    (wdata_i),
        .value_o    (pin_one)
    );
    pfcs_reg8 #(.RESET_VAL(pfcs_pkg::RST_PIN_TWO), .WR_MASK(pfcs_pkg::MSK_ALL)) u_two (
        .clock_i    (clock_i),
        .arst_n_i   (arst_n_i),
        .sw_reset_i (sw_reset_i),
        .we_i       (we_two),
        .wdata_i    (wdata_i),
        .value_o    (pin_two)
    );
    pfcs_reg8 #(.RESET_VAL(pfcs_pkg::RST_PIN_THREE), .WR_MASK(pfcs_pkg::MSK_PIN_THREE)) u_three (
        .clock_i    (clock_i),
        .arst_n_i   (arst_n_i),
        .sw_reset_i (sw_reset_i),
        .we_i       (we_three),
        .wdata_i    (wdata_i),
        .value_o    (pin_three)
    );
    pfcs_reg8 #(.RESET_VAL(pfcs_pkg::RST_PIN_FOUR), .WR_MASK(pfcs_pkg::MSK_PIN_FOUR)) u_four (
        .clock_i    (clock_i),
        .arst_n_i   (arst_n_i),
        .sw_reset_i (sw_reset_i),
        .we_i       (we_four),
        .wdata_i    (wdata_i),
        .value_o    (pin_four)
    );
    pfcs_reg8 #(.RESET_VAL(pfcs_pkg::RST_PRESET), .WR_MASK(pfcs_pkg::MSK_PRESET)) u_preset (
        .clock_i    (clock_i),
        .arst_n_i   (arst_n_i),
        .sw_reset_i (sw_reset_i),
        .we_i       (we_preset),
        .wdata_i    (wdata_i),
        .value_o    (preset)
    );
    pfcs_reg8 #(.RESET_VAL(pfcs_pkg::RST_CHAN), .WR_MASK(pfcs_pkg::MSK_ALL)) u_chan (
        .clock_i    (clock_i),
        .arst_n_i   (arst_n_i),
        .sw_reset_i (sw_reset_i),
        .we_i       (we_chan),
        .wdata_i    (wdata_i),
        .value_o    (chan)
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [7:0] rdata_sel;
    logic [7:0] rdata_d;

    // Reserved bits read zero, unmapped reads zero
    assign rdata_sel = (addr_i == pfcs_pkg::OFF_PIN_ONE)   ? pin_one
                     : (addr_i == pfcs_pkg::OFF_PIN_TWO)   ? pin_two
                     : (addr_i == pfcs_pkg::OFF_PIN_THREE) ? (pin_three & pfcs_pkg::MSK_PIN_THREE)
                     : (addr_i == pfcs_pkg::OFF_PIN_FOUR)  ? (pin_four & pfcs_pkg::MSK_PIN_FOUR)
                     : (addr_i == pfcs_pkg::OFF_PRESET)    ? (preset & pfcs_pkg::MSK_PRESET)
                     : (addr_i == pfcs_pkg::OFF_CHAN)      ? chan
                     : 8'h00;
    assign rdata_d = rd_i ? rdata_sel : 8'h00;

    // ----------------------------------------
    // Pin role decode
    // ----------------------------------------
    pfcs_pkg::pfcs_func_t func_d;
    logic                 vid;

    function automatic pfcs_pkg::pfcs_role3_t role3(input logic [1:0] sel);
        pfcs_pkg::pfcs_role3_t r;
        r = pfcs_pkg::PFCS_ROLE_ALARM;
        if (sel == pfcs_pkg::SEL2_00) begin
            r = pfcs_pkg::PFCS_ROLE_BASE;
        end else if (sel == pfcs_pkg::SEL2_01) begin
            r = pfcs_pkg::PFCS_ROLE_ALT;
        end
        return r;
    endfunction

    assign vid = pin_one[7];

    always_comb begin
        func_d                               = '0;
        func_d.first_12v_monitor             = ~pin_one[0];
        func_d.fan_speed_input_five          = pin_one[0];
        func_d.voltage_identification_inputs = vid;
        for (int i = 0; i < 4; i++) begin
            func_d.fan_speed_input_1_4[i] = ~vid & pin_one[4 - i];
            func_d.gpio_1_4[i]            = ~vid & ~pin_one[4 - i];
        end
        func_d.remote_diode_three_pair = pin_one[5];
        func_d.termination_sense_two   = ~pin_one[5];
        func_d.remote_diode_one_pair   = pin_one[6];
        func_d.termination_sense_one   = ~pin_one[6];
        func_d.pin23_rail              = pfcs_pkg::pfcs_rail_t'(pin_two[1:0]);
        func_d.fan_speed_input_6_8     = {pin_two[2], pin_two[3], pin_two[7]};
        func_d.pin19_low_scale         = ~pin_one[5] & pin_two[4];
        func_d.pin15_low_scale         = ~pin_one[6] & pin_two[5];
        func_d.pwm_four_drive          = pin_two[6];
        func_d.chassis_intrusion       = pin_three[1];
        func_d.force_fan_full_input    = ~pin_three[1];
        func_d.pin26_role              = role3(pin_three[3:2]);
        func_d.pin25_role              = role3(pin_three[5:4]);
        func_d.pin24_rail              = pfcs_pkg::pfcs_rail_t'(pin_three[7:6]);
        func_d.pwm_1_2_drive[1]        = ~vid & pin_four[2];
        func_d.pwm_1_2_drive[0]        = ~vid & pin_four[3];
        func_d.gpio_5_6[1]             = ~vid & ~pin_four[2];
        func_d.gpio_5_6[0]             = ~vid & ~pin_four[3];
        func_d.pin29_role              = role3(pin_four[5:4]);
        func_d.pin28_role              = vid ? pfcs_pkg::PFCS_ROLE_BASE : role3(pin_four[7:6]);
        func_d.preset_enable           = preset[4:0];
        func_d.special_output_enable   = chan[1:0];
        func_d.single_channel_mode     = chan[2];
        func_d.channel_select          = chan[7:3];
    end

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
            func_o  <= '0;
        end else begin
            rdata_o <= rdata_d;
            func_o  <= func_d;
        end
    end
endmodule

// *** tb/pfcs_host.sv ***
// Host software model driving the register port.
// Assumes read data valid one cycle after the read strobe.
`timescale 1ns/1ps
module pfcs_host (
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o = 8'h00,
    output logic      [7:0] wdata_o = 8'h00,
    output logic            wr_o = 1'b0,
    output logic            rd_o = 1'b0
);
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clock_i);
        wr_o <= 1'b0;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clock_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule

// *** tb/pfcs_top_properties.sv ***
// Port checks for the pin select bank.
// Assumes binding onto pfcs_top; single clock domain.
`timescale 1ns/1ps
module pfcs_top_properties (
    input wire logic                 clock_i,
    input wire logic                 arst_n_i,
    input wire logic                 sw_reset_i,
    input wire logic                 lock_i,
    input wire logic [7:0]           addr_i,
    input wire logic [7:0]           wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [7:0]           rdata_o,
    input wire pfcs_pkg::pfcs_func_t func_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr(logic [7:0] a);
        wr_i && !lock_i && !sw_reset_i && addr_i == a;
    endsequence
    property p_rd_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_pin7;
        s_wr(pfcs_pkg::OFF_PIN_ONE) |-> ##2
            (func_o.fan_speed_input_five == $past(wdata_i[0], 2) && func_o.first_12v_monitor != $past(wdata_i[0], 2));
    endproperty
    a_pin7: assert property (p_pin7) else $error("pin 7 role wrong");
    property p_role25;
        s_wr(pfcs_pkg::OFF_PIN_THREE) |-> ##2
            func_o.pin25_role == ($past(wdata_i[5], 2) ? 2'h2 : {1'b0, $past(wdata_i[4], 2)});
    endproperty
    a_role25: assert property (p_role25) else $error("pin 25 role wrong");
    property p_chan;
        s_wr(pfcs_pkg::OFF_CHAN) |-> ##2
            {func_o.channel_select, func_o.single_channel_mode, func_o.special_output_enable} == $past(wdata_i, 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel control wrong");
    property p_lock;
        wr_i && lock_i && !sw_reset_i |-> ##2 $stable(func_o);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write took effect");
    property p_swrst;
        sw_reset_i |-> ##2 (func_o.pin23_rail == pfcs_pkg::PFCS_RAIL_1V8 && func_o.preset_enable == 5'h01
            && func_o.chassis_intrusion && !func_o.voltage_identification_inputs);
    endproperty
    a_swrst: assert property (p_swrst) else $error("soft reset defaults wrong");
    property p_preset_rsv;
        rd_i && addr_i == pfcs_pkg::OFF_PRESET |=> rdata_o[7:5] == 3'h0;
    endproperty
    a_preset_rsv: assert property (p_preset_rsv) else $error("preset reserved bits set");
    property p_unmapped;
        rd_i && addr_i == 8'h15 |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_vid;
        func_o.voltage_identification_inputs |-> (func_o.gpio_1_4 == 4'h0 && func_o.fan_speed_input_1_4 == 4'h0
            && func_o.pwm_1_2_drive == 2'h0);
    endproperty
    a_vid: assert property (p_vid) else $error("identification override missing");
    property p_diode;
        func_o.remote_diode_three_pair |-> !func_o.pin19_low_scale;
    endproperty
    a_diode: assert property (p_diode) else $error("pin 19 scale with diode on");
endmodule

bind pfcs_top pfcs_top_properties pfcs_top_properties_inst (.clock_i, .arst_n_i, .sw_reset_i, .lock_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .func_o);

// *** tb/tb_pfcs_top.sv ***
// Register-level testbench for the pin select bank.
// Assumes pfcs_host as bus master and the bound checker.
`timescale 1ns/1ps
module tb_pfcs_top;
    logic                 clock_i = 1'b0;
    logic                 arst_n_i = 1'b0;
    logic                 sw_reset_i = 1'b0;
    logic                 lock_i = 1'b0;
    logic [7:0]           addr_i, wdata_i, rdata_o;
    logic                 wr_i, rd_i;
    pfcs_pkg::pfcs_func_t func_o;
    int                   n_errors = 0;
    int                   total_checks = 0;
    logic [7:0] offs [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16};
    logic [7:0] rsts [6] = '{8'h7F, 8'hCE, 8'h42, 8'hFC, 8'h01, 8'h00};
    logic [7:0] msks [6] = '{8'hFF, 8'hFF, 8'hFE, 8'hFC, 8'h1F, 8'hFF};

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    pfcs_top pfcs_top_inst (.clock_i, .arst_n_i, .sw_reset_i, .lock_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .func_o);
    pfcs_host pfcs_host_inst (.clock_i(clock_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        pfcs_host_inst.read(a, v);
        chk($sformatf("reg %h", a), exp, v);
    endtask
    task automatic settle;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 6; i++) rchk(offs[i], rsts[i]);
        rchk(8'h15, 8'h00);
        for (int i = 0; i < 6; i++) pfcs_host_inst.write(offs[i], 8'hFF);
        for (int i = 0; i < 6; i++) rchk(offs[i], msks[i]);
        settle;
        chk("vid", 8'h01, func_o.voltage_identification_inputs);
        chk("gpio14", 8'h00, func_o.gpio_1_4);
        chk("role28", 8'h00, func_o.pin28_role);
        chk("role29", 8'h02, func_o.pin29_role);
        chk("chan", 8'hFF, {func_o.channel_select, func_o.single_channel_mode, func_o.special_output_enable});
        @(posedge clock_i) lock_i <= 1'b1;
        pfcs_host_inst.write(8'h10, 8'h00);
        @(posedge clock_i) lock_i <= 1'b0;
        rchk(8'h10, 8'hFF);
        pfcs_host_inst.write(8'h10, 8'h00);
        pfcs_host_inst.write(8'h11, 8'h30);
        settle;
        chk("pin7", 8'h01, func_o.first_12v_monitor);
        chk("gpio14", 8'h0F, func_o.gpio_1_4);
        chk("scale", 8'h03, {func_o.pin19_low_scale, func_o.pin15_low_scale});
        chk("pin13", 8'h00, func_o.pwm_four_drive);
        chk("fan68", 8'h00, func_o.fan_speed_input_6_8);
        chk("term2", 8'h01, func_o.termination_sense_two);
        chk("term1", 8'h01, func_o.termination_sense_one);
        chk("rail23", 8'h00, func_o.pin23_rail);
        chk("pwm12", 8'h03, func_o.pwm_1_2_drive);
        for (int k = 0; k < 4; k++) begin
            pfcs_host_inst.write(8'h12, {k[1:0], k[1:0], k[1:0], k[0], 1'b0});
            settle;
            chk("role25", k[1] ? 8'h02 : 8'(k), func_o.pin25_role);
            chk("role26", k[1] ? 8'h02 : 8'(k), func_o.pin26_role);
            chk("rail24", 8'(k), func_o.pin24_rail);
            chk("pin27", {6'h0, k[0], ~k[0]}, {func_o.chassis_intrusion, func_o.force_fan_full_input});
        end
        pfcs_host_inst.write(8'h13, 8'h50);
        settle;
        chk("alt2829", 8'h11, {func_o.pin28_role, 2'h0, func_o.pin29_role});
        chk("gpio56", 8'h03, func_o.gpio_5_6);
        @(posedge clock_i) sw_reset_i <= 1'b1;
        @(posedge clock_i) sw_reset_i <= 1'b0;
        rchk(8'h11, 8'hCE);
        rchk(8'h10, 8'h7F);
        conclude;
    end

    initial begin
        repeat (2000) @(posedge clock_i);
        n_errors++;
        conclude;
    end
endmodule
